/* File: design/elc_pkg.sv */
// Shared constants for the Ethernet link control and status block
package elc_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_RESYNC   = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_INT_STAT = 8'h0C;
  localparam logic [7:0] ADDR_INT_CLR  = 8'h10;
  localparam logic [7:0] ADDR_INT_EN   = 8'h14;

  // Control register fields
  localparam int CTRL_TX_EN     = 0;
  localparam int CTRL_SEND_RFI  = 1;
  localparam int CTRL_SEND_IDLE = 2;
  localparam int CTRL_RX_EN     = 3;
  localparam int CTRL_W         = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Status register fields
  localparam int ST_DEC_LSB    = 0;
  localparam int ST_LFAULT     = 2;
  localparam int ST_TX_PKT     = 3;
  localparam int ST_RX_PKT     = 4;
  localparam int ST_RX_RFI     = 5;
  localparam int ST_LOCK_LSB   = 8;

  // Interrupt status fields
  localparam int IRQ_LFAULT  = 0;
  localparam int IRQ_ALIGNED = 1;
  localparam int IRQ_FRAMERR = 2;
  localparam int IRQ_W       = 3;

  // Lanes and widths
  localparam int LANES  = 4;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 4;

  // Lane monitor timing counts, in received blocks
  localparam logic [2:0] WIN_LAST   = 3'h7;
  localparam logic [3:0] LOCK_GOOD  = 4'hF;
  localparam logic [3:0] LOSS_ERRS  = 4'h4;

  // Sync header codes (valid ones differ in both bits)
  localparam logic [1:0] HDR_DATA = 2'h1;
  localparam logic [1:0] HDR_CTRL = 2'h2;

  // Link code word types
  typedef enum logic [1:0] {
    ELC_W_IDLE = 2'b00,
    ELC_W_DATA = 2'b01,
    ELC_W_END  = 2'b10,
    ELC_W_RFI  = 2'b11
  } elc_word_t;

  // Receive decoder states
  typedef enum logic [1:0] {
    ELC_DEC_STARTUP = 2'b00,
    ELC_DEC_ALIGN   = 2'b01,
    ELC_DEC_RUN     = 2'b10
  } elc_dec_t;
endpackage

/* File: design/elc_lane_mon.sv */
// Per-lane sync header checker: lock tracking and error counts
`timescale 1ns/1ps
`default_nettype none
module elc_lane_mon (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Control
  input  wire logic                    run_i,
  input  wire logic                    clear_i,
  // Synchronised sync header
  input  wire logic [1:0]              hdr_i,
  // Status
  output logic [elc_pkg::CNT_W-1:0]    err_cnt_o,
  output logic                         err_vld_o,
  output logic                         locked_o
);
  logic [2:0]                 win;
  logic [elc_pkg::CNT_W-1:0]  errs;
  logic [3:0]                 good;
  logic                       bad;

  assign bad = (hdr_i != elc_pkg::HDR_DATA) && (hdr_i != elc_pkg::HDR_CTRL);

  // Window of eight blocks; errors summed, reported at its end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      win       <= 3'h0;
      errs      <= 4'h0;
      err_cnt_o <= 4'h0;
      err_vld_o <= 1'b0;
    end else if (clear_i) begin
      win       <= 3'h0;
      errs      <= 4'h0;
      err_vld_o <= 1'b0;
    end else if (run_i) begin
      win <= win + 3'h1;
      if (win == elc_pkg::WIN_LAST) begin
        errs      <= 4'h0;
        err_cnt_o <= errs + {3'h0, bad};
        err_vld_o <= 1'b1;
      end else begin
        errs      <= errs + {3'h0, bad};
        err_vld_o <= 1'b0;
      end
    end else begin
      // Halted decoder reports nothing
      err_vld_o <= 1'b0;
    end
  end

  // Lock after a run of good headers, lost on a bad window
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      good     <= 4'h0;
      locked_o <= 1'b0;
    end else if (clear_i) begin
      good     <= 4'h0;
      locked_o <= 1'b0;
    end else if (run_i) begin
      if (bad) begin
        good <= 4'h0;
      end else if (good != elc_pkg::LOCK_GOOD) begin
        good <= good + 4'h1;
      end
      if (!bad && good == elc_pkg::LOCK_GOOD) begin
        locked_o <= 1'b1;
      end else if (win == elc_pkg::WIN_LAST &&
                   (errs + {3'h0, bad}) >= elc_pkg::LOSS_ERRS) begin
        locked_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: design/elc_link_ctrl.sv */
// Ethernet link control and status: TX gating, RX decoder, APB regs
`timescale 1ns/1ps
`default_nettype none
module elc_link_ctrl (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // APB slave
  input  wire logic [7:0]                  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // User transmit stream
  input  wire logic                        tx_valid_i,
  input  wire logic [elc_pkg::DATA_W-1:0]  tx_data_i,
  input  wire logic                        tx_last_i,
  output logic                             tx_ready_o,
  // Link transmit words
  output logic [1:0]                       link_tx_type_o,
  output logic [elc_pkg::DATA_W-1:0]       link_tx_data_o,
  // Link receive pins
  input  wire logic [1:0]                  link_rx_type_i,
  input  wire logic [elc_pkg::DATA_W-1:0]  link_rx_data_i,
  input  wire logic [7:0]                  link_rx_hdr_i,
  // User receive stream
  output logic                             rx_valid_o,
  output logic [elc_pkg::DATA_W-1:0]       rx_data_o,
  output logic                             rx_last_o,
  // Status
  output logic                             tx_local_fault_o,
  output logic [3:0]                       framing_err_0_o,
  output logic [3:0]                       framing_err_1_o,
  output logic [3:0]                       framing_err_2_o,
  output logic [3:0]                       framing_err_3_o,
  output logic [3:0]                       framing_err_valid_o,
  output logic                             irq_o
);
  logic [elc_pkg::CTRL_W-1:0]  ctrl;
  logic                        resync;
  logic [elc_pkg::IRQ_W-1:0]   int_stat;
  logic [elc_pkg::IRQ_W-1:0]   int_en;
  logic [elc_pkg::IRQ_W-1:0]   events;
  logic [elc_pkg::IRQ_W-1:0]   next_int_stat;
  logic                        wr_go;
  logic                        tx_in_pkt;
  logic                        next_tx_in_pkt;
  logic                        tx_accept;
  logic                        force_rfi;
  logic                        force_idle;
  logic [1:0]                  rx_type_m;
  logic [1:0]                  rx_type_s;
  logic [elc_pkg::DATA_W-1:0]  rx_data_m;
  logic [elc_pkg::DATA_W-1:0]  rx_data_s;
  logic [7:0]                  rx_hdr_m;
  logic [7:0]                  rx_hdr_s;
  elc_pkg::elc_dec_t           dec_state;
  elc_pkg::elc_dec_t           next_dec;
  logic                        rx_in_pkt;
  logic                        rx_gate;
  logic                        rx_take;
  logic                        rx_rfi;
  logic                        lane_run;
  logic                        lane_clear;
  logic [3:0]                  lane_lock;
  logic [3:0]                  lane_vld;
  logic [3:0]                  lane_cnt [4];
  logic                        any_err;

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  // APB: one wait-free access, answer registered from the setup phase
  assign wr_go = psel && penable && pready && pwrite;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable) begin
        unique case (paddr)
          elc_pkg::ADDR_CTRL: prdata <= {28'h0, ctrl};
          elc_pkg::ADDR_STATUS: begin
            prdata[elc_pkg::ST_DEC_LSB +: 2]  <= dec_state;
            prdata[elc_pkg::ST_LFAULT]        <= tx_local_fault_o;
            prdata[elc_pkg::ST_TX_PKT]        <= tx_in_pkt;
            prdata[elc_pkg::ST_RX_PKT]        <= rx_in_pkt;
            prdata[elc_pkg::ST_RX_RFI]        <= rx_rfi;
            prdata[elc_pkg::ST_LOCK_LSB +: 4] <= lane_lock;
          end
          elc_pkg::ADDR_INT_STAT: prdata <= {29'h0, int_stat};
          elc_pkg::ADDR_INT_EN:   prdata <= {29'h0, int_en};
          elc_pkg::ADDR_RESYNC,
          elc_pkg::ADDR_INT_CLR:  prdata <= 32'h0;
          default:                pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Control bits steer the TX and RX paths
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl   <= elc_pkg::CTRL_RESET;
      int_en <= 3'h0;
    end else if (wr_go) begin
      if (is_reg(paddr, elc_pkg::ADDR_CTRL)) begin
        ctrl <= pwdata[elc_pkg::CTRL_W-1:0];
      end
      if (is_reg(paddr, elc_pkg::ADDR_INT_EN)) begin
        int_en <= pwdata[elc_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      resync <= 1'b0;
    end else begin
      resync <= wr_go && is_reg(paddr, elc_pkg::ADDR_RESYNC) && pwdata[0];
    end
  end

  // Transmit path
  assign force_rfi  = ctrl[elc_pkg::CTRL_SEND_RFI];
  assign force_idle = ctrl[elc_pkg::CTRL_SEND_IDLE];
  assign tx_accept  = tx_valid_i && tx_ready_o;

  always_comb begin
    next_tx_in_pkt = tx_in_pkt;
    if (force_rfi || force_idle) begin
      next_tx_in_pkt = 1'b0;
    end else if (tx_accept) begin
      next_tx_in_pkt = !tx_last_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_in_pkt  <= 1'b0;
      tx_ready_o <= 1'b0;
    end else begin
      tx_in_pkt  <= next_tx_in_pkt;
      tx_ready_o <= !force_rfi && !force_idle &&
                    (next_tx_in_pkt || ctrl[elc_pkg::CTRL_TX_EN]);
    end
  end

  // Forced words outrank data; remote fault outranks idle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_tx_type_o <= elc_pkg::ELC_W_IDLE;
      link_tx_data_o <= 32'h0;
    end else begin
      link_tx_data_o <= 32'h0;
      if (force_rfi) begin
        link_tx_type_o <= elc_pkg::ELC_W_RFI;
      end else if (force_idle || !tx_accept) begin
        link_tx_type_o <= elc_pkg::ELC_W_IDLE;
      end else begin
        link_tx_type_o <= tx_last_i ? elc_pkg::ELC_W_END
                                    : elc_pkg::ELC_W_DATA;
        link_tx_data_o <= tx_data_i;
      end
    end
  end

  // Link pins pass two flops before any logic
  // pins synced first
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_type_m <= 2'h0;
      rx_type_s <= 2'h0;
      rx_data_m <= 32'h0;
      rx_data_s <= 32'h0;
      rx_hdr_m  <= 8'h0;
      rx_hdr_s  <= 8'h0;
    end else begin
      rx_type_m <= link_rx_type_i;
      rx_type_s <= rx_type_m;
      rx_data_m <= link_rx_data_i;
      rx_data_s <= rx_data_m;
      rx_hdr_m  <= link_rx_hdr_i;
      rx_hdr_s  <= rx_hdr_m;
    end
  end

  // decoding continues until the open packet ends
  assign rx_gate    = ctrl[elc_pkg::CTRL_RX_EN] || rx_in_pkt;
  assign lane_run   = rx_gate && (dec_state != elc_pkg::ELC_DEC_STARTUP);
  assign lane_clear = resync || (dec_state == elc_pkg::ELC_DEC_STARTUP);

  always_comb begin
    next_dec = dec_state;
    unique case (dec_state)
      elc_pkg::ELC_DEC_STARTUP:
        if (rx_gate) next_dec = elc_pkg::ELC_DEC_ALIGN;
      elc_pkg::ELC_DEC_ALIGN:
        if (&lane_lock) next_dec = elc_pkg::ELC_DEC_RUN;
      elc_pkg::ELC_DEC_RUN:
        if (!(&lane_lock)) next_dec = elc_pkg::ELC_DEC_STARTUP;
      default: next_dec = elc_pkg::ELC_DEC_STARTUP;
    endcase
    if (resync) begin
      next_dec = elc_pkg::ELC_DEC_STARTUP;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dec_state        <= elc_pkg::ELC_DEC_STARTUP;
      tx_local_fault_o <= 1'b1;
    end else begin
      dec_state        <= next_dec;
      tx_local_fault_o <= (next_dec == elc_pkg::ELC_DEC_STARTUP);
    end
  end

  // Receive words reach the user only while decoding runs
  assign rx_take = lane_run && (dec_state == elc_pkg::ELC_DEC_RUN) &&
                   (rx_type_s == elc_pkg::ELC_W_DATA ||
                    rx_type_s == elc_pkg::ELC_W_END);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_valid_o <= 1'b0;
      rx_data_o  <= 32'h0;
      rx_last_o  <= 1'b0;
      rx_in_pkt  <= 1'b0;
      rx_rfi     <= 1'b0;
    end else begin
      rx_valid_o <= rx_take;
      rx_data_o  <= rx_take ? rx_data_s : 32'h0;
      rx_last_o  <= rx_take && (rx_type_s == elc_pkg::ELC_W_END);
      rx_rfi     <= (rx_type_s == elc_pkg::ELC_W_RFI);
      if (lane_clear) begin
        // Realign drops a partial packet
        rx_in_pkt <= 1'b0;
      end else if (rx_take) begin
        rx_in_pkt <= (rx_type_s == elc_pkg::ELC_W_DATA);
      end
    end
  end

  for (genvar g = 0; g < elc_pkg::LANES; g++) begin : g_lane
    elc_lane_mon u_mon (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .run_i     (lane_run),
      .clear_i   (lane_clear),
      .hdr_i     (rx_hdr_s[2*g +: 2]),
      .err_cnt_o (lane_cnt[g]),
      .err_vld_o (lane_vld[g]),
      .locked_o  (lane_lock[g])
    );
  end

  assign framing_err_0_o     = lane_cnt[0];
  assign framing_err_1_o     = lane_cnt[1];
  assign framing_err_2_o     = lane_cnt[2];
  assign framing_err_3_o     = lane_cnt[3];
  assign framing_err_valid_o = lane_vld;

  // Interrupts: a new event beats a clear in the same cycle
  always_comb begin
    any_err = 1'b0;
    for (int i = 0; i < elc_pkg::LANES; i++) begin
      any_err = any_err || (lane_vld[i] && lane_cnt[i] != 4'h0);
    end
    events = '0;
    events[elc_pkg::IRQ_LFAULT] = !tx_local_fault_o &&
      (next_dec == elc_pkg::ELC_DEC_STARTUP);
    events[elc_pkg::IRQ_ALIGNED] = (dec_state != elc_pkg::ELC_DEC_RUN) &&
      (next_dec == elc_pkg::ELC_DEC_RUN);
    events[elc_pkg::IRQ_FRAMERR] = any_err;
    next_int_stat = int_stat;
    if (wr_go && is_reg(paddr, elc_pkg::ADDR_INT_CLR)) begin
      next_int_stat = int_stat & ~pwdata[elc_pkg::IRQ_W-1:0];
    end
    next_int_stat = next_int_stat | events;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_stat <= 3'h0;
      irq_o    <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      irq_o    <= |(next_int_stat & int_en);
    end
  end
endmodule
`default_nettype wire

/* File: test/elc_link_ctrl_props.sv */
// Port-level assertions for the link control and status block
`timescale 1ns/1ps
`default_nettype none
module elc_link_ctrl_props (
  // Clock, reset and bus
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Streams
  input  wire logic        tx_valid_i,
  input  wire logic [31:0] tx_data_i,
  input  wire logic        tx_last_i,
  input  wire logic        tx_ready_o,
  input  wire logic [1:0]  link_tx_type_o,
  input  wire logic [31:0] link_tx_data_o,
  input  wire logic        rx_valid_o,
  input  wire logic [31:0] rx_data_o,
  input  wire logic        rx_last_o,
  // Status
  input  wire logic        tx_local_fault_o,
  input  wire logic [3:0]  framing_err_0_o,
  input  wire logic [3:0]  framing_err_valid_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_take;
    tx_valid_i && tx_ready_o;
  endsequence

  AST_APB_ANSWER: assert property (s_setup |=> pready)
    else $error("no answer one cycle after setup");
  AST_APB_PULSE: assert property (pready |=> !pready)
    else $error("pready held beyond one cycle");
  AST_APB_ERR: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  AST_TX_TAKE: assert property (s_take |=>
    link_tx_type_o == {$past(tx_last_i), !$past(tx_last_i)}
    && link_tx_data_o == $past(tx_data_i))
    else $error("taken word not sent next cycle");
  AST_TX_NO_TAKE: assert property (!(tx_valid_i && tx_ready_o) |=>
    link_tx_type_o inside {elc_pkg::ELC_W_IDLE, elc_pkg::ELC_W_RFI})
    else $error("data word sent without a take");
  AST_TX_QUIET: assert property (link_tx_type_o[1] == link_tx_type_o[0]
    |-> link_tx_data_o == 32'h0)
    else $error("idle or fault word carries data");
  AST_LFAULT_RX: assert property (tx_local_fault_o
    && $past(tx_local_fault_o) |-> !rx_valid_o)
    else $error("word delivered while decoder in startup");
  AST_FE_WINDOW: assert property (framing_err_valid_o[0]
    |=> !framing_err_valid_o[0] [*7])
    else $error("lane count strobes closer than a window");
  AST_FE_RANGE: assert property (framing_err_valid_o[0]
    |-> framing_err_0_o <= 4'h8)
    else $error("lane count above window size");
  AST_RX_QUIET: assert property (!rx_valid_o
    |-> rx_data_o == 32'h0 && !rx_last_o)
    else $error("user receive bus not idle");
endmodule

bind elc_link_ctrl elc_link_ctrl_props i_props (
  .clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i), .tx_last_i(tx_last_i),
  .tx_ready_o(tx_ready_o), .link_tx_type_o(link_tx_type_o),
  .link_tx_data_o(link_tx_data_o), .rx_valid_o(rx_valid_o),
  .rx_data_o(rx_data_o), .rx_last_o(rx_last_o),
  .tx_local_fault_o(tx_local_fault_o), .framing_err_0_o(framing_err_0_o),
  .framing_err_valid_o(framing_err_valid_o)
);
`default_nettype wire

/* File: test/elc_link_partner.sv */
// Far-end link partner model: sync headers, code words, idle junk
`timescale 1ns/1ps
`default_nettype none
module elc_link_partner (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Commands from the bench
  input  wire logic [3:0]  err_lane_i,
  input  wire logic [1:0]  word_type_i,
  input  wire logic [31:0] word_data_i,
  // Link pins
  output logic [1:0]       link_rx_type_o,
  output logic [31:0]      link_rx_data_o,
  output logic [7:0]       link_rx_hdr_o
);
  logic [31:0] noise;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      noise <= 32'h0;
      link_rx_type_o <= 2'h0;
      link_rx_data_o <= 32'h0;
      link_rx_hdr_o <= 8'h0;
    end else begin
      noise <= noise + 32'h9E3779B9;
      link_rx_type_o <= word_type_i;
      // Idle words carry junk so the block must ignore them
      link_rx_data_o <= (word_type_i inside {2'h1, 2'h2}) ? word_data_i
                                                           : ~noise;
      for (int i = 0; i < 4; i++) begin
        link_rx_hdr_o[2*i +: 2] <= err_lane_i[i] ? {2{noise[1]}}
                                                 : {noise[0], !noise[0]};
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the link control and status block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tx_valid_i = 1'b0;
  logic [31:0] tx_data_i = 32'h0;
  logic        tx_last_i = 1'b0;
  logic        tx_ready_o;
  logic [1:0]  tx_type;
  logic [31:0] tx_word;
  logic [1:0]  rx_type;
  logic [31:0] rx_word;
  logic [7:0]  rx_hdr;
  logic        rx_valid_o;
  logic [31:0] rx_data_o;
  logic        rx_last_o;
  logic        lfault;
  logic [3:0]  fe [4];
  logic [3:0]  fe_vld;
  logic        irq_o;
  logic [3:0]  err_lane = 4'h0;
  logic [1:0]  word_type = 2'h0;
  logic [31:0] word_data = 32'h0;
  logic [31:0] rd;
  logic        err;
  int          errors = 0;
  int          check_count = 0;
  int          rx_cnt = 0;
  int          last_cnt = 0;
  int          fv_cnt = 0;
  int          lf_cnt = 0;
  int          a, b;
  int          fe_sum [4] = '{default: 0};
  int          fe_base [4];
  logic [31:0] rx_seen = 32'h0;

  always #20 clk_i = ~clk_i;

  elc_link_ctrl i_elc_link_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_valid_i(tx_valid_i),
    .tx_data_i(tx_data_i), .tx_last_i(tx_last_i), .tx_ready_o(tx_ready_o),
    .link_tx_type_o(tx_type), .link_tx_data_o(tx_word),
    .link_rx_type_i(rx_type), .link_rx_data_i(rx_word),
    .link_rx_hdr_i(rx_hdr), .rx_valid_o(rx_valid_o),
    .rx_data_o(rx_data_o), .rx_last_o(rx_last_o),
    .tx_local_fault_o(lfault), .framing_err_0_o(fe[0]),
    .framing_err_1_o(fe[1]), .framing_err_2_o(fe[2]),
    .framing_err_3_o(fe[3]), .framing_err_valid_o(fe_vld), .irq_o(irq_o)
  );

  elc_link_partner i_elc_link_partner (
    .clk_i(clk_i), .rst_i(rst_i), .err_lane_i(err_lane),
    .word_type_i(word_type), .word_data_i(word_data),
    .link_rx_type_o(rx_type), .link_rx_data_o(rx_word),
    .link_rx_hdr_o(rx_hdr)
  );

  // Running tallies, the way user logic would keep them
  always @(posedge clk_i) begin
    if (rx_valid_o === 1'b1) begin
      rx_cnt++;
      rx_seen = rx_data_o;
    end
    if (rx_last_o === 1'b1) last_cnt++;
    if (lfault === 1'b1) lf_cnt++;
    for (int i = 0; i < 4; i++) begin
      if (fe_vld[i] === 1'b1) begin
        fv_cnt++;
        fe_sum[i] += int'(fe[i]);
      end
    end
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] wd);
    @(posedge clk_i);
    psel <= 1'b1;
    paddr <= ad;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    // Any wait state ends on pready; only the watchdog bounds a hang
    while (pready !== 1'b1) @(posedge clk_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [7:0] ad,
                      input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    check(name, rd & mask, exp);
  endtask

  task automatic send(input logic [31:0] d, input logic l);
    tx_valid_i <= 1'b1;
    tx_data_i <= d;
    tx_last_i <= l;
    @(posedge clk_i);
    while (tx_ready_o !== 1'b1) @(posedge clk_i);
    tx_valid_i <= 1'b0;
    // Word launched at the take edge stands until the next one
    @(posedge clk_i);
    check("link type", {30'h0, tx_type}, {30'h0, l, !l});
    check("link data", tx_word, d);
  endtask

  task automatic wait_run();
    int n;
    n = 0;
    do begin
      apb(1'b0, elc_pkg::ADDR_STATUS, 32'h0);
      n++;
    end while (rd[1:0] !== 2'h2 && n < 40);
    check("decoder", {30'h0, rd[1:0]}, 32'h2);
  endtask

  task automatic close_out();
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    check("lfault", {31'h0, lfault}, 32'h1);
    rchk("ctrl", elc_pkg::ADDR_CTRL, 32'hF, 32'h0);
    rchk("status", elc_pkg::ADDR_STATUS, 32'h7, 32'h4);
    apb(1'b0, 8'h20, 32'h0);
    check("slverr", {31'h0, err}, 32'h1);
    // Hold remote fault until our own receiver aligns
    apb(1'b1, elc_pkg::ADDR_CTRL, 32'hA);
    repeat (3) @(posedge clk_i);
    check("rfi", {30'h0, tx_type}, 32'h3);
    wait_run();
    check("lfault", {31'h0, lfault}, 32'h0);
    apb(1'b1, elc_pkg::ADDR_CTRL, 32'h9);
    send(32'h11111111, 1'b0);
    send(32'h22222222, 1'b1);
    @(posedge clk_i);
    #1;
    check("idle after", {30'h0, tx_type}, 32'h0);
    // Enable dropped in mid-packet
    send(32'h33333333, 1'b0);
    apb(1'b1, elc_pkg::ADDR_CTRL, 32'h8);
    send(32'h44444444, 1'b1);
    repeat (2) @(posedge clk_i);
    check("ready off", {31'h0, tx_ready_o}, 32'h0);
    // Partner signals remote fault, so force idle
    word_type <= 2'h3;
    apb(1'b1, elc_pkg::ADDR_CTRL, 32'hD);
    repeat (2) @(posedge clk_i);
    tx_valid_i <= 1'b1;
    repeat (4) begin
      @(posedge clk_i);
      check("forced idle", {30'h0, tx_type}, 32'h0);
      check("ready forced", {31'h0, tx_ready_o}, 32'h0);
    end
    tx_valid_i <= 1'b0;
    rchk("rx rfi", elc_pkg::ADDR_STATUS, 32'h20, 32'h20);
    word_type <= 2'h0;
    apb(1'b1, elc_pkg::ADDR_CTRL, 32'h8);
    a = rx_cnt;
    b = last_cnt;
    word_type <= 2'h1;
    word_data <= 32'hA5A5A5A5;
    @(posedge clk_i);
    word_type <= 2'h2;
    word_data <= 32'hC3C3C3C3;
    @(posedge clk_i);
    word_type <= 2'h0;
    repeat (8) @(posedge clk_i);
    check("rx words", 32'(rx_cnt - a), 32'h2);
    check("rx last", 32'(last_cnt - b), 32'h1);
    check("rx data", rx_seen, 32'hC3C3C3C3);
    // Two bad headers on lane 1
    fe_base = fe_sum;
    err_lane <= 4'h2;
    repeat (2) @(posedge clk_i);
    err_lane <= 4'h0;
    repeat (24) @(posedge clk_i);
    for (int i = 0; i < 4; i++) begin
      check("lane errs", 32'(fe_sum[i] - fe_base[i]),
            (i == 1) ? 2 : 0);
    end
    rchk("int frame", elc_pkg::ADDR_INT_STAT, 32'h4, 32'h4);
    // Realign with startup interrupt enabled, then masked
    apb(1'b1, elc_pkg::ADDR_INT_CLR, 32'h7);
    apb(1'b1, elc_pkg::ADDR_INT_EN, 32'h1);
    a = lf_cnt;
    apb(1'b1, elc_pkg::ADDR_RESYNC, 32'h1);
    rchk("realign", elc_pkg::ADDR_STATUS, 32'h7, 32'h4);
    check("lfault seen", {31'h0, lf_cnt > a}, 32'h1);
    check("irq on", {31'h0, irq_o}, 32'h1);
    apb(1'b1, elc_pkg::ADDR_INT_EN, 32'h0);
    repeat (2) @(posedge clk_i);
    check("irq masked", {31'h0, irq_o}, 32'h0);
    rchk("int sticky", elc_pkg::ADDR_INT_STAT, 32'h1, 32'h1);
    apb(1'b1, elc_pkg::ADDR_INT_CLR, 32'h1);
    rchk("int clear", elc_pkg::ADDR_INT_STAT, 32'h1, 32'h0);
    wait_run();
    // Disable inside a packet: its end word is still delivered
    a = rx_cnt;
    word_type <= 2'h1;
    @(posedge clk_i);
    word_type <= 2'h0;
    apb(1'b1, elc_pkg::ADDR_CTRL, 32'h0);
    word_type <= 2'h2;
    @(posedge clk_i);
    word_type <= 2'h0;
    repeat (8) @(posedge clk_i);
    check("rx finish", 32'(rx_cnt - a), 32'h2);
    // Receive disabled: words and statistics stop
    a = rx_cnt;
    b = fv_cnt;
    word_type <= 2'h1;
    repeat (4) @(posedge clk_i);
    word_type <= 2'h0;
    repeat (20) @(posedge clk_i);
    check("rx off", 32'(rx_cnt - a), 32'h0);
    check("stats off", 32'(fv_cnt - b), 32'h0);
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
